// File: design/sdt_consts.svh
/*
 * timing counts, field codes and widths of the write-burst path
 * assumes inclusion by bare name from every design file that needs it
 */
`ifndef SDT_CONSTS_SVH
`define SDT_CONSTS_SVH

// burst-length field codes
`define SDT_BL_FIXED8        2'h0
`define SDT_BL_OTF           2'h1
`define SDT_BL_FIXED_CHOP    2'h2

// beat counts used by capture and turnaround
`define SDT_BEATS_FULL       4'h8
`define SDT_BEATS_CHOP       4'h4

// strobe edges tolerated around the nominal write-latency position
`define SDT_STROBE_SLACK     4'h6

// data and latency widths
`define SDT_DATA_W           16
`define SDT_LAT_W            5

// entries in the beat buffer
`define SDT_BUF_DEPTH        2

`endif

// File: design/sdt_pkg.sv
/*
 * types shared by the write-burst path and its beat buffer
 * assumes sdt_consts.svh is reachable by bare name
 */
`include "sdt_consts.svh"

package sdt_pkg;

	typedef logic [`SDT_DATA_W-1:0] sdt_word_t;

	// one captured beat with its attributes
	typedef struct packed {
		sdt_word_t data;
		logic      suspect;
		logic      last;
	} sdt_beat_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_BURST
	} sdt_state_t;

endpackage : sdt_pkg

// File: design/sdt_beat_if.sv
/*
 * beat handshake between the capture core and its buffer
 * assumes one clock shared by both ends
 */
`timescale 1ns/10ps

interface sdt_beat_if;
	import sdt_pkg::*;

	sdt_beat_t inBeat;
	logic      inValid;
	logic      inReady;
	sdt_beat_t outBeat;
	logic      outValid;
	logic      outReady;

	modport core (output inBeat, output inValid, input inReady,
		input outBeat, input outValid, output outReady);
	modport store (input inBeat, input inValid, output inReady,
		output outBeat, output outValid, input outReady);
endinterface : sdt_beat_if

// File: design/sdt_beat_fifo.sv
/*
 * two-entry beat buffer with valid/ready on both sides
 * assumes synchronous active-low reset on clk
 */
`timescale 1ns/10ps
`include "sdt_consts.svh"

module sdt_beat_fifo #(
	parameter int DEPTH = `SDT_BUF_DEPTH
) (
	input  wire logic clk,
	input  wire logic rst_n,
	sdt_beat_if.store bus
);
	import sdt_pkg::*;

	sdt_beat_t   mem [DEPTH];
	logic        wrPtr_q;
	logic        rdPtr_q;
	logic [1:0]  count_q;
	logic        push;
	logic        pop;

	////////////////////////////////////////////////////////////////////////////
	// honest full and empty
	assign bus.inReady  = (count_q != 2'(DEPTH));
	assign bus.outValid = (count_q != 2'h0);
	assign bus.outBeat  = mem[rdPtr_q];
	assign push         = bus.inValid && bus.inReady;
	assign pop          = bus.outValid && bus.outReady;

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q] <= bus.inBeat;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push) begin
				wrPtr_q <= ~wrPtr_q;
			end
			if (pop) begin
				rdPtr_q <= ~rdPtr_q;
			end
			count_q <= count_q + 2'(push) - 2'(pop);
		end
	end

	chk_fifo_no_overfill : assert property (@(posedge clk) disable iff (!rst_n)
		count_q <= 2'(DEPTH)) else $error("beat buffer overfilled");
endmodule : sdt_beat_fifo

// File: design/sdt_write_path.sv
/*
 * write-burst capture path of the memory device: command sampling,
 * burst-length choice, strobe capture, violation tolerance, recovery mark
 * assumes all pins asynchronous to clk and much slower than it
 */
`timescale 1ns/10ps
`include "sdt_consts.svh"

// Overview of operation
// - turnaround read beats are 8 for eight-beat reads and 4 for chopped reads.
// - turnaround write beats are 4 only in fixed chop mode and 8 otherwise.
// - data setup or hold violations may store wrong data but never hang the device.
// - strobe faults spoil that write and flag later ones suspect until all-idle, with checksum and per-command burst off.
// - a read after an offending write is always accepted.
// - same-bank writes after the long column spacing are taken, data possibly wrong.
// - other-group writes after the short column spacing are taken, data possibly wrong.
// - once every bank is idle after precharge, later good writes store correct data.
// - an eight-beat write takes eight strobe edges at half-clock spacing from latency.
// - recovery counts from the first rise after the last beat, with inversion variants.
// - in per-command mode address bit 12 high gives eight beats and low gives four.
// - in fixed chop mode every write is four beats whatever the address bit.
module sdt_write_path (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  linkClk,
	input  wire logic                  cmdWritePin,
	input  wire logic                  cmdReadPin,
	input  wire logic                  burstSelPin,
	input  wire logic                  strobePin,
	input  wire sdt_pkg::sdt_word_t    dataPin,
	input  wire logic [1:0]            burstLengthField,
	input  wire logic [`SDT_LAT_W-1:0] writeLatencySetting,
	input  wire logic                  checksumEnable,
	input  wire logic                  writeInversion,
	input  wire logic                  allBanksIdle,
	output sdt_pkg::sdt_word_t         beatData,
	output logic                       beatSuspect,
	output logic                       beatLast,
	output logic                       beatValid,
	input  wire logic                  beatReady,
	output logic                       readAccepted,
	output logic                       recoveryStart,
	output logic [3:0]                 writeBurstBeats,
	output logic [3:0]                 readBurstBeats,
	output logic                       useInversionDelays,
	output logic                       toleranceHolds,
	output logic                       writeSuspect,
	output logic                       burstAborted
);
	import sdt_pkg::*;

	localparam int PW = `SDT_DATA_W + 5;

	logic [PW-1:0]         meta_q;
	logic [PW-1:0]         sync_q;
	logic                  ckPrev_q;
	logic                  dqsPrev_q;
	logic                  ckRise;
	logic                  dqsEdge;
	logic                  wrTake;
	logic                  rdTake;
	logic [3:0]            cmdBeats;
	sdt_state_t            state_q;
	logic [`SDT_LAT_W-1:0] latCnt_q;
	logic [3:0]            curBeats_q;
	logic [3:0]            beatCnt_q;
	logic [3:0]            ckInBurst_q;
	logic                  pendValid_q;
	logic [`SDT_LAT_W-1:0] pendCnt_q;
	logic [3:0]            pendBeats_q;
	logic                  lastDone_q;
	logic                  captureEv;
	logic                  openEv;
	logic [3:0]            beatIdx;
	logic                  abortEv;
	logic                  lostBeat;
	sdt_beat_if            beatBus ();

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, first stage read only by the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {linkClk, cmdWritePin, cmdReadPin, burstSelPin, strobePin, dataPin};
			sync_q <= meta_q;
		end
	end

	// edge history of the synchronised clocks
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ckPrev_q  <= 1'b0;
			dqsPrev_q <= 1'b0;
		end else begin
			ckPrev_q  <= sync_q[PW-1];
			dqsPrev_q <= sync_q[`SDT_DATA_W];
		end
	end

	assign ckRise  = sync_q[PW-1] && !ckPrev_q;
	assign dqsEdge = sync_q[`SDT_DATA_W] != dqsPrev_q;
	assign wrTake  = ckRise && sync_q[PW-2];
	assign rdTake  = ckRise && sync_q[PW-3];

	// beats of the write being taken
	always_comb begin
		case (burstLengthField)
			`SDT_BL_FIXED_CHOP: cmdBeats = `SDT_BEATS_CHOP;
			`SDT_BL_OTF:        cmdBeats = sync_q[PW-4] ? `SDT_BEATS_FULL
			                                             : `SDT_BEATS_CHOP;
			default:            cmdBeats = `SDT_BEATS_FULL;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// turnaround beat counts and delay variant reported to the controller side
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			writeBurstBeats    <= `SDT_BEATS_FULL;
			readBurstBeats     <= `SDT_BEATS_FULL;
			useInversionDelays <= 1'b0;
			toleranceHolds     <= 1'b0;
			readAccepted       <= 1'b0;
		end else begin
			if (wrTake) begin
				writeBurstBeats <= (burstLengthField == `SDT_BL_FIXED_CHOP)
					? `SDT_BEATS_CHOP : `SDT_BEATS_FULL;
			end
			if (rdTake) begin
				readBurstBeats <= cmdBeats;
			end
			useInversionDelays <= writeInversion;
			toleranceHolds     <= !checksumEnable && (burstLengthField != `SDT_BL_OTF);
			readAccepted       <= rdTake;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// burst sequencer: latency wait, capture, strobe-slack abort
	// the opening rise may carry the first strobe edge, both synchronised alike
	assign openEv    = (state_q == ST_WAIT) && ckRise && (latCnt_q <= `SDT_LAT_W'(1));
	assign captureEv = dqsEdge && (openEv || ((state_q == ST_BURST) && !lastDone_q));
	assign beatIdx   = openEv ? 4'h0 : beatCnt_q;
	assign abortEv   = (state_q == ST_BURST) && ckRise
		&& (ckInBurst_q >= (curBeats_q >> 1) + (`SDT_STROBE_SLACK >> 1));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q     <= ST_IDLE;
			latCnt_q    <= '0;
			curBeats_q  <= `SDT_BEATS_FULL;
			beatCnt_q   <= 4'h0;
			ckInBurst_q <= 4'h0;
			lastDone_q  <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (wrTake) begin
						state_q    <= ST_WAIT;
						latCnt_q   <= writeLatencySetting;
						curBeats_q <= cmdBeats;
					end
				end
				ST_WAIT: begin
					if (ckRise) begin
						if (latCnt_q <= `SDT_LAT_W'(1)) begin
							state_q     <= ST_BURST;
							beatCnt_q   <= {3'h0, dqsEdge};
							ckInBurst_q <= 4'h0;
							lastDone_q  <= 1'b0;
						end else begin
							latCnt_q <= latCnt_q - `SDT_LAT_W'(1);
						end
					end
				end
				ST_BURST: begin
					if (captureEv) begin
						beatCnt_q  <= beatCnt_q + 4'h1;
						lastDone_q <= (beatCnt_q + 4'h1 == curBeats_q);
					end
					if (ckRise) begin
						ckInBurst_q <= ckInBurst_q + 4'h1;
					end
					if ((ckRise && lastDone_q) || abortEv) begin
						// a queued write takes over with its remaining latency
						state_q    <= pendValid_q ? ST_WAIT : ST_IDLE;
						latCnt_q   <= pendCnt_q;
						curBeats_q <= pendBeats_q;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// one write queued while another waits or bursts, its latency counted meanwhile
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pendValid_q <= 1'b0;
			pendCnt_q   <= '0;
			pendBeats_q <= `SDT_BEATS_FULL;
		end else if (wrTake && state_q != ST_IDLE) begin
			pendValid_q <= 1'b1;
			pendCnt_q   <= writeLatencySetting;
			pendBeats_q <= cmdBeats;
		end else begin
			if (ckRise && pendValid_q && pendCnt_q > `SDT_LAT_W'(1)) begin
				pendCnt_q <= pendCnt_q - `SDT_LAT_W'(1);
			end
			if (state_q == ST_BURST && ((ckRise && lastDone_q) || abortEv)) begin
				pendValid_q <= 1'b0;
			end
		end
	end

	// recovery mark on the first rising clock after the last beat
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			recoveryStart <= 1'b0;
			burstAborted  <= 1'b0;
		end else begin
			recoveryStart <= (state_q == ST_BURST) && ckRise && lastDone_q;
			burstAborted  <= abortEv;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// suspect-data flag: set by a lost or aborted burst, cleared by all-idle
	assign lostBeat = captureEv && !beatBus.inReady;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			writeSuspect <= 1'b0;
		end else if (abortEv || lostBeat) begin
			writeSuspect <= 1'b1;
		end else if (allBanksIdle) begin
			writeSuspect <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// beat buffer between capture and the array port
	assign beatBus.inValid        = captureEv;
	assign beatBus.inBeat.data    = sync_q[`SDT_DATA_W-1:0];
	assign beatBus.inBeat.suspect = writeSuspect;
	assign beatBus.inBeat.last    = (beatIdx + 4'h1 == curBeats_q);
	assign beatBus.outReady       = beatReady;

	sdt_beat_fifo u_fifo (
		.clk   (clk),
		.rst_n (rst_n),
		.bus   (beatBus.store)
	);

	assign beatValid   = beatBus.outValid;
	assign beatData    = beatBus.outBeat.data;
	assign beatSuspect = beatBus.outBeat.suspect;
	assign beatLast    = beatBus.outBeat.last;

	////////////////////////////////////////////////////////////////////////////
	chk_chop_fixed_beats : assert property (@(posedge clk) disable iff (!rst_n)
		wrTake && state_q == ST_IDLE && burstLengthField == `SDT_BL_FIXED_CHOP
		|=> curBeats_q == 4'h4) else $error("fixed chop not four beats");
	chk_otf_select_beats : assert property (@(posedge clk) disable iff (!rst_n)
		wrTake && state_q == ST_IDLE && burstLengthField == `SDT_BL_OTF
		|=> curBeats_q == ($past(sync_q[PW-4]) ? 4'h8 : 4'h4))
		else $error("per-command burst choice wrong");
	chk_otf_write_turn : assert property (@(posedge clk) disable iff (!rst_n)
		wrTake && burstLengthField == `SDT_BL_OTF |=> writeBurstBeats == 4'h8)
		else $error("per-command write turnaround not eight");
	chk_read_turn_beats : assert property (@(posedge clk) disable iff (!rst_n)
		rdTake && burstLengthField == `SDT_BL_OTF && !sync_q[PW-4]
		|=> readBurstBeats == 4'h4) else $error("chopped read not four");
	chk_read_accepted : assert property (@(posedge clk) disable iff (!rst_n)
		rdTake |=> readAccepted ##1 !readAccepted || rdTake)
		else $error("read not accepted");
	chk_recovery_mark : assert property (@(posedge clk) disable iff (!rst_n)
		beatBus.inValid && beatBus.inBeat.last |-> ##[1:40] recoveryStart)
		else $error("recovery mark missing after last beat");
	chk_abort_flags_data : assert property (@(posedge clk) disable iff (!rst_n)
		abortEv |=> writeSuspect && burstAborted && state_q != ST_BURST)
		else $error("abort not flagged or burst hung");
	chk_idle_clears : assert property (@(posedge clk) disable iff (!rst_n)
		allBanksIdle && !abortEv && !lostBeat |=> !writeSuspect)
		else $error("suspect flag not cleared when idle");
	chk_beats_in_burst : assert property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_BURST |-> beatCnt_q <= curBeats_q)
		else $error("more beats than burst length");
endmodule : sdt_write_path

// File: sim/sdt_ctrl_model.sv
/*
 * controller model: free-running link clock, commands, strobe and write data
 * assumes the bench calls its tasks one at a time from a single process
 */
`timescale 1ns/10ps
`include "sdt_consts.svh"

module sdt_ctrl_model #(
	parameter int WL    = 3,
	parameter int RL    = 5,
	parameter int WTR_L = 4,
	parameter int WTR_S = 2,
	parameter int PRE   = 1
) (
	input  wire logic          clk,
	output logic               linkClk,
	output logic               cmdWritePin,
	output logic               cmdReadPin,
	output logic               burstSelPin,
	output logic               strobePin,
	output sdt_pkg::sdt_word_t dataPin
);
	import sdt_pkg::*;

	int linkCount = 0;
	int lastRdAt  = -100;
	int lastWrAt  = -100;
	int lastWrGrp = 0;
	int rdBeats   = 8;
	int wrBeats   = 8;

	////////////////////////////////////////////////////////////////////////
	// link clock, phase unrelated to clk; calibration assumed done
	initial begin
		linkClk = 1'b0;
		cmdWritePin = 1'b0;
		cmdReadPin = 1'b0;
		burstSelPin = 1'b0;
		strobePin = 1'b0;
		dataPin = 16'hFFFF;
		#37;
		forever #80 linkClk = ~linkClk;
	end

	// link rise counter used for spacing
	always @(posedge linkClk) begin
		linkCount <= linkCount + 1;
	end

	////////////////////////////////////////////////////////////////////////
	// command pins held from one link fall to the next
	task automatic sendCmd(input logic isWr, input logic bsel);
		@(negedge linkClk);
		@(posedge clk);
		cmdWritePin <= isWr;
		cmdReadPin  <= ~isWr;
		burstSelPin <= bsel;
		@(negedge linkClk);
		@(posedge clk);
		cmdWritePin <= 1'b0;
		cmdReadPin  <= 1'b0;
		burstSelPin <= ~bsel; // released: inverse of last value
	endtask : sendCmd

	task automatic waitUntil(input int at);
		while (linkCount < at) @(posedge clk);
	endtask : waitUntil

	// read after write spacing, per bank group
	task automatic doRead(input int grp, input logic bsel, input int rb);
		waitUntil(lastWrAt + WL + wrBeats / 2 + ((grp == lastWrGrp) ? WTR_L : WTR_S));
		sendCmd(1'b0, bsel);
		lastRdAt = linkCount;
		rdBeats = rb;
	endtask : doRead

	// write after read spacing, then strobe edges on link edges from latency
	task automatic doWrite(input int grp, input logic bsel, input int wb, input int toggles,
			input sdt_word_t base);
		int i;
		waitUntil(lastRdAt + RL - WL + rdBeats / 2 + 1 + PRE);
		sendCmd(1'b1, bsel);
		lastWrAt = linkCount;
		lastWrGrp = grp;
		wrBeats = wb;
		waitUntil(lastWrAt + WL - 1);
		@(negedge linkClk);
		repeat (4) @(posedge clk);
		for (i = 0; i < toggles; i++) begin
			dataPin <= sdt_word_t'(base + i);
			// data settles about a quarter strobe period ahead of its edge
			if (i[0]) @(negedge linkClk);
			else @(posedge linkClk);
			strobePin <= ~strobePin;
			repeat (4) @(posedge clk);
		end
		dataPin <= ~sdt_word_t'(base + toggles - 1); // released data line
	endtask : doWrite
endmodule : sdt_ctrl_model

// File: sim/tb_top.sv
/*
 * self-checking bench of the write-burst path with a controller model
 * assumes the design files and sdt_consts.svh are compiled first
 */
`timescale 1ns/10ps
`include "sdt_consts.svh"

module tb_top;
	import sdt_pkg::*;

	localparam int WL = 3;
	logic clk, rst_n, linkClk, cmdWritePin, cmdReadPin, burstSelPin, strobePin;
	logic checksumEnable, writeInversion, allBanksIdle, beatReady;
	logic beatSuspect, beatLast, beatValid, readAccepted, recoveryStart;
	logic useInversionDelays, toleranceHolds, writeSuspect, burstAborted;
	logic [1:0] burstLengthField;
	logic [3:0] writeBurstBeats, readBurstBeats;
	sdt_word_t  dataPin, beatData;
	sdt_word_t  gotData[$];
	logic       gotLast[$];
	logic       gotSusp[$];
	int miscompares = 0;
	int totalChecks = 0;
	int rdSeen, recSeen, abortSeen;

	////////////////////////////////////////////////////////////////////////
	sdt_write_path dut (.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
		.cmdWritePin(cmdWritePin), .cmdReadPin(cmdReadPin), .burstSelPin(burstSelPin),
		.strobePin(strobePin), .dataPin(dataPin), .burstLengthField(burstLengthField),
		.writeLatencySetting(5'(WL)), .checksumEnable(checksumEnable),
		.writeInversion(writeInversion), .allBanksIdle(allBanksIdle), .beatData(beatData),
		.beatSuspect(beatSuspect), .beatLast(beatLast), .beatValid(beatValid),
		.beatReady(beatReady), .readAccepted(readAccepted), .recoveryStart(recoveryStart),
		.writeBurstBeats(writeBurstBeats), .readBurstBeats(readBurstBeats),
		.useInversionDelays(useInversionDelays), .toleranceHolds(toleranceHolds),
		.writeSuspect(writeSuspect), .burstAborted(burstAborted));

	sdt_ctrl_model #(.WL(WL)) ctrl (.clk(clk), .linkClk(linkClk), .cmdWritePin(cmdWritePin),
		.cmdReadPin(cmdReadPin), .burstSelPin(burstSelPin), .strobePin(strobePin),
		.dataPin(dataPin));

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// popped beats and output pulses
	always @(posedge clk) begin
		if (beatValid === 1'b1 && beatReady === 1'b1) begin
			gotData.push_back(beatData);
			gotLast.push_back(beatLast);
			gotSusp.push_back(beatSuspect);
		end
		if (readAccepted === 1'b1) rdSeen++;
		if (recoveryStart === 1'b1) recSeen++;
		if (burstAborted === 1'b1) abortSeen++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		totalChecks++;
		if (seen !== want) begin
			miscompares++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, want);
		end
	endtask : check

	task complete_run;
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	// one write burst, optionally with the consumer stalled until 20 clocks after the write
	task automatic runWrite(input int grp, input logic bsel, input int full, input int n,
			input logic [3:0] wb, input sdt_word_t base, input logic stall, input logic sus);
		int i;
		int q0;
		int rec0;
		q0 = gotData.size();
		rec0 = recSeen;
		beatReady <= ~stall;
		ctrl.doWrite(grp, bsel, int'(wb), full, base);
		repeat (20) @(posedge clk);
		beatReady <= 1'b1;
		repeat (40) @(posedge clk);
		check(16'(gotData.size() - q0), 16'(n), "beat count");
		for (i = 0; i < n && q0 + i < gotData.size(); i++) begin
			check(gotData[q0 + i], sdt_word_t'(base + i), "beat data");
			check(16'(gotLast[q0 + i]), 16'(i == full - 1), "last flag");
			check(16'(gotSusp[q0 + i]), 16'(sus), "beat suspect");
		end
		check(16'(recSeen - rec0), 16'h0001, "recovery pulse");
		check(16'(writeBurstBeats), 16'(wb), "write beats");
		$display("test write %h done", base);
	endtask : runWrite

	task automatic runRead(input int grp, input logic bsel, input logic [3:0] rb);
		int rd0;
		rd0 = rdSeen;
		ctrl.doRead(grp, bsel, int'(rb));
		repeat (10) @(posedge clk);
		check(16'(rdSeen - rd0), 16'h0001, "read taken");
		check(16'(readBurstBeats), 16'(rb), "read beats");
		$display("test read done");
	endtask : runRead

	////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#500_000;
		miscompares++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run;
	end

	// main sequence
	initial begin
		int f, cs, ab0;
		rst_n = 1'b0;
		burstLengthField = `SDT_BL_FIXED8;
		checksumEnable = 1'b0;
		writeInversion = 1'b0;
		allBanksIdle = 1'b0;
		beatReady = 1'b1;
		repeat (10) @(posedge clk);
		check(16'(writeBurstBeats), 16'h0008, "reset write beats");
		check(16'(readBurstBeats), 16'h0008, "reset read beats");
		check(16'({beatValid, writeSuspect}), 16'h0000, "reset flags");
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		for (f = 0; f < 4; f++) begin
			for (cs = 0; cs < 2; cs++) begin
				burstLengthField <= 2'(f);
				checksumEnable <= cs[0];
				writeInversion <= cs[0];
				repeat (3) @(posedge clk);
				check(16'(toleranceHolds), 16'(cs == 0 && f != 1), "tolerance");
				check(16'(useInversionDelays), 16'(cs), "inversion");
			end
		end
		checksumEnable <= 1'b0;
		burstLengthField <= `SDT_BL_FIXED8;
		$display("test flags done");
		runWrite(0, 1'b0, 8, 8, 4'h8, 16'h1000, 1'b0, 1'b0);
		runRead(0, 1'b0, 4'h8);
		burstLengthField <= `SDT_BL_OTF;
		runWrite(0, 1'b1, 8, 8, 4'h8, 16'h2000, 1'b0, 1'b0);
		runWrite(1, 1'b0, 4, 4, 4'h8, 16'h3000, 1'b0, 1'b0);
		runRead(1, 1'b1, 4'h8);
		runRead(0, 1'b0, 4'h4);
		burstLengthField <= `SDT_BL_FIXED_CHOP;
		runWrite(0, 1'b1, 4, 4, 4'h4, 16'h4000, 1'b0, 1'b0);
		runRead(0, 1'b1, 4'h4);
		burstLengthField <= `SDT_BL_FIXED8;
		runWrite(0, 1'b1, 8, 2, 4'h8, 16'h5000, 1'b1, 1'b0);
		check(16'(writeSuspect), 16'h0001, "overflow suspect");
		ab0 = abortSeen;
		ctrl.doWrite(0, 1'b1, 8, 2, 16'h6000);
		repeat (150) @(posedge clk);
		check(16'(abortSeen - ab0), 16'h0001, "abort pulse");
		check(16'(writeSuspect), 16'h0001, "abort suspect");
		$display("test abort done");
		runRead(1, 1'b1, 4'h8);
		runWrite(0, 1'b1, 8, 8, 4'h8, 16'h7000, 1'b0, 1'b1);
		runWrite(1, 1'b1, 8, 8, 4'h8, 16'h8000, 1'b0, 1'b1);
		check(16'(writeSuspect), 16'h0001, "sticky suspect");
		allBanksIdle <= 1'b1;
		repeat (2) @(posedge clk);
		allBanksIdle <= 1'b0;
		repeat (2) @(posedge clk);
		check(16'(writeSuspect), 16'h0000, "idle clears");
		runWrite(0, 1'b1, 8, 8, 4'h8, 16'h9000, 1'b0, 1'b0);
		check(16'(writeSuspect), 16'h0000, "good write");
		complete_run;
	end
endmodule : tb_top
